// >>> strap_rom_pkg.sv
`default_nettype none
package strap_rom_pkg;
  // Register indices of the captured strap values and the memory config register
  localparam logic [7:0] IDX_STRAP_CAPTURE_LOW = 8'h36;
  localparam logic [7:0] IDX_STRAP_CAPTURE_HIGH = 8'h37;
  localparam logic [7:0] IDX_MEM_CONFIG = 8'h31;
  localparam int MEM_CONFIG_FULL_BIOS_BIT = 7;
  // Strap field positions
  localparam int STRAP_BUS_LO = 0;
  localparam int STRAP_ROM_WIDTH = 2;
  localparam int STRAP_BIOS_FULL = 3;
  localparam int STRAP_UPPER_SEL = 4;
  localparam int STRAP_MEM_LO = 5;
  localparam int STRAP_SETUP_SEL = 8;
  localparam int STRAP_RESERVED = 9;
  localparam int STRAP_MON_EXT = 10;
  localparam int STRAP_NO_WAIT = 11;
  localparam int STRAP_CLAIM_SEL = 12;
  localparam int STRAP_MON_LO = 13;
  // Host bus codes
  typedef enum logic [1:0] {
    BUS_EISA = 2'b00,
    BUS_LOCAL = 2'b01,
    BUS_RSVD = 2'b10,
    BUS_ISA = 2'b11
  } bus_type_e;
  // Display memory size codes
  localparam logic [2:0] MEM_4MB = 3'h0;
  localparam logic [2:0] MEM_3MB = 3'h2;
  localparam logic [2:0] MEM_2MB = 3'h4;
  localparam logic [2:0] MEM_1MB = 3'h6;
  localparam logic [2:0] MEM_HALF_MB = 3'h7;
  // BIOS window, 20-bit CPU addresses
  localparam logic [19:0] BIOS_BASE = 20'hc0000;
  localparam logic [19:0] BIOS_LAST = 20'hc7fff;
  localparam logic [19:0] BIOS_HOLE_BASE = 20'hc6000;
  localparam logic [19:0] BIOS_HOLE_LAST = 20'hc67ff;
  localparam int ROM_ADDR_W = 15;
  // Decoded configuration carried to the decoder
  typedef struct packed {
    bus_type_e bus;
    logic rom_8bit;
    logic bios_full_strap;
    logic upper_sel;
    logic [2:0] mem_size;
    logic setup_sel;
    logic no_wait_en;
    logic claim_internal;
    logic [3:0] monitor_code;
  } strap_cfg_s;
  // Bus cycle request from the host side
  typedef struct packed {
    logic [19:0] addr;
    logic mem_read;
    logic mem_write;
  } host_cycle_s;
endpackage : strap_rom_pkg
`default_nettype wire

// >>> bios_rom_decode.sv
`default_nettype none
// Combinational BIOS window decode and ROM address translation
module bios_rom_decode
  import strap_rom_pkg::*;
(
  // Request
  input wire strap_rom_pkg::host_cycle_s i_cycle,
  input wire logic i_full_range,
  // Decode results
  output logic o_hit,
  output logic [strap_rom_pkg::ROM_ADDR_W-1:0] o_rom_addr
);
  logic in_window;
  logic in_hole;
  // Hole is skipped unless the full range is granted
  always_comb begin
    in_window = (i_cycle.addr >= BIOS_BASE) && (i_cycle.addr <= BIOS_LAST);
    in_hole = (i_cycle.addr >= BIOS_HOLE_BASE) && (i_cycle.addr <= BIOS_HOLE_LAST);
    o_hit = in_window && (i_full_range || !in_hole);
    o_rom_addr = i_cycle.addr[ROM_ADDR_W-1:0];
  end
endmodule // bios_rom_decode
`default_nettype wire

// >>> strap_rom_ctrl.sv
`default_nettype none
// What this block does
// - Reset idles select, buffer enable and claim outputs and clears config bit 7; straps are kept
// - Reset fall captures fifteen straps into registers
// - Straps 1:0 choose EISA, local or ISA
// - ISA strap 2 picks 8 or 16-bit ROM
// - ISA strap 3 opens or closes BIOS hole
// - ISA strap 4 picks wide-cycle address range
// - Local strap 4 low makes pin a select
// - Straps 7:5 give display memory size
// - Strap 8 picks setup bit or enables local
// - Strap 11 sets no-wait or claim style
// - Strap 12 sets wide claim or DAC claim
// - Straps 15:13,10 monitor code; bit 9 one
// - ISA maps BIOS addresses, drives ROM select
// - No wide claim on 8-bit ROM reads
// - Buffer direction and enables generated for ROM
// - Local select only on valid BIOS addresses
// - Standard window is 30 KB around hole
// - Config bit 7 forces full 32 KB range
module strap_rom_ctrl
  import strap_rom_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Strap pins shared with pixel data
  input wire logic [15:0] i_strap_pixel_bus,
  // Host cycle and upper address lines
  input wire strap_rom_pkg::host_cycle_s i_cycle,
  input wire logic [23:16] i_upper_addr,
  input wire logic i_dac_access,
  // Configuration register port
  input wire logic [7:0] i_reg_index,
  input wire logic i_reg_write,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Upper-address pin, input or select output
  input wire logic i_upper_address_decode_two,
  output logic o_upper_address_decode_two,
  output logic o_upper_address_decode_two_oe_n,
  // ROM and buffer controls
  output logic o_bios_rom_select_n,
  output logic o_buffer_direction,
  output logic o_low_byte_buffer_enable_n,
  output logic o_high_byte_buffer_enable_n,
  // Bus claims, open-drain style
  output logic o_wide_memory_cycle_claim_n,
  output logic o_wide_memory_cycle_claim_oe_n,
  output logic o_no_wait_state_n,
  output logic o_local_bus_claim_n,
  output logic o_local_bus_claim_oe_n,
  output logic o_cycle_ready_out,
  // Decoded configuration
  output strap_rom_pkg::strap_cfg_s o_cfg,
  output logic o_device_enable
);
  logic rst_q;
  logic [15:0] straps;
  logic mem_cfg_full;
  logic [15:0] next_straps;
  logic next_mem_cfg_full;
  strap_cfg_s cfg;
  logic bios_hit;
  logic [ROM_ADDR_W-1:0] rom_addr;
  logic is_isa;
  logic is_local;
  logic rom_sel_active;
  logic rom_read;
  logic wide_hit;
  logic [7:0] next_rdata;
  logic next_rom_sel_n;
  logic next_dir;
  logic next_enl_n;
  logic next_enh_n;
  logic next_wide_n;
  logic next_wide_oe_n;
  logic next_no_wait_state_n;
  logic next_claim_n;
  logic next_claim_oe_n;
  logic next_ready;
  logic next_pin_out;
  logic next_pin_oe_n;
  logic [ROM_ADDR_W-1:0] rom_addr_q;

  // Field decoding of captured straps, used by several outputs
  function automatic strap_cfg_s decode_straps(input logic [15:0] s);
    strap_cfg_s c;
    c.bus = bus_type_e'(s[STRAP_BUS_LO +: 2]);
    c.rom_8bit = s[STRAP_ROM_WIDTH];
    c.bios_full_strap = s[STRAP_BIOS_FULL];
    c.upper_sel = s[STRAP_UPPER_SEL];
    c.mem_size = s[STRAP_MEM_LO +: 3];
    c.setup_sel = s[STRAP_SETUP_SEL];
    c.no_wait_en = s[STRAP_NO_WAIT];
    c.claim_internal = s[STRAP_CLAIM_SEL];
    c.monitor_code = {s[STRAP_MON_LO +: 3], s[STRAP_MON_EXT]};
    return c;
  endfunction

  // Capture on the reset falling edge; pins may carry pixel data afterwards
  always_comb begin
    next_straps = straps;
    if (rst_q && !i_rst) begin
      next_straps = i_strap_pixel_bus;
      next_straps[STRAP_RESERVED] = 1'b1;
    end
    next_mem_cfg_full = mem_cfg_full;
    if (i_rst) begin
      next_mem_cfg_full = 1'b0;
    end else if (i_reg_write && i_reg_index == IDX_MEM_CONFIG) begin
      next_mem_cfg_full = i_reg_wdata[MEM_CONFIG_FULL_BIOS_BIT];
    end
  end

  // Straps are not cleared by reset: they are loaded as it ends
  always_ff @(posedge i_clk) begin
    rst_q <= i_rst;
    straps <= next_straps;
    mem_cfg_full <= next_mem_cfg_full;
  end

  assign cfg = decode_straps(straps);
  assign is_isa = (cfg.bus == BUS_ISA);
  assign is_local = (cfg.bus == BUS_LOCAL);

  bios_rom_decode u_decode (
    .i_cycle(i_cycle),
    .i_full_range(mem_cfg_full || cfg.bios_full_strap),
    .o_hit(bios_hit),
    .o_rom_addr(rom_addr)
  );

  // Select only where a ROM is owned by this device
  always_comb begin
    rom_read = bios_hit && i_cycle.mem_read;
    rom_sel_active = 1'b0;
    if (is_isa) begin
      rom_sel_active = rom_read;
    end else if (is_local && !cfg.upper_sel) begin
      rom_sel_active = rom_read;
    end
    // Wide-cycle range: strap 4 low also needs SA16 (from address bit 16)
    if (cfg.upper_sel) begin
      wide_hit = (i_upper_addr[23:17] == {4'h0, BIOS_BASE[19:17]});
    end else begin
      wide_hit = (i_upper_addr[23:17] == {4'h0, BIOS_BASE[19:17]}) && (i_upper_addr[16] == BIOS_BASE[16]);
    end
  end

  // Output decode; registered so every pin comes from a flip-flop
  always_comb begin
    next_rom_sel_n = !rom_sel_active;
    next_dir = i_cycle.mem_write; // Low for reads, high for writes
    next_enl_n = 1'b1;
    next_enh_n = 1'b1;
    if (is_isa && rom_read) begin
      next_dir = 1'b0;
      next_enl_n = 1'b0;
      next_enh_n = cfg.rom_8bit;
    end
    // Wide claim released for 8-bit ROM reads
    next_wide_n = 1'b1;
    next_wide_oe_n = 1'b1;
    if (is_isa && cfg.claim_internal && wide_hit && !(rom_read && cfg.rom_8bit)) begin
      next_wide_n = 1'b0;
      next_wide_oe_n = 1'b0;
    end
    next_no_wait_state_n = !(is_isa && cfg.no_wait_en && rom_read);
    // Local claim: level style always driven, other style floats when idle
    next_claim_n = 1'b1;
    next_claim_oe_n = is_local && !cfg.no_wait_en ? 1'b0 : 1'b1;
    next_ready = 1'b0;
    if (is_local && o_device_enable && (bios_hit || (i_dac_access && cfg.claim_internal))) begin
      next_claim_n = 1'b0;
      next_claim_oe_n = 1'b0;
      next_ready = 1'b1;
    end
    // Upper pin turned to select output only in local mode, strap 4 low
    next_pin_out = next_rom_sel_n;
    next_pin_oe_n = !(is_local && !cfg.upper_sel);
    unique case (i_reg_index)
      IDX_STRAP_CAPTURE_LOW: next_rdata = straps[7:0];
      IDX_STRAP_CAPTURE_HIGH: next_rdata = straps[15:8];
      IDX_MEM_CONFIG: next_rdata = {mem_cfg_full, 7'h00};
      default: next_rdata = 8'h00;
    endcase
    if (i_rst) begin
      next_rom_sel_n = 1'b1;
      next_enl_n = 1'b1;
      next_enh_n = 1'b1;
      next_wide_n = 1'b1;
      next_wide_oe_n = 1'b1;
      next_no_wait_state_n = 1'b1;
      next_claim_n = 1'b1;
      next_claim_oe_n = 1'b1;
      next_ready = 1'b0;
      next_pin_oe_n = 1'b1;
    end
  end

  // Output registers
  always_ff @(posedge i_clk) begin
    o_reg_rdata <= next_rdata;
    o_bios_rom_select_n <= next_rom_sel_n;
    o_buffer_direction <= next_dir;
    o_low_byte_buffer_enable_n <= next_enl_n;
    o_high_byte_buffer_enable_n <= next_enh_n;
    o_wide_memory_cycle_claim_n <= next_wide_n;
    o_wide_memory_cycle_claim_oe_n <= next_wide_oe_n;
    o_no_wait_state_n <= next_no_wait_state_n;
    o_local_bus_claim_n <= next_claim_n;
    o_local_bus_claim_oe_n <= next_claim_oe_n;
    o_cycle_ready_out <= next_ready;
    o_upper_address_decode_two <= next_pin_out;
    o_upper_address_decode_two_oe_n <= next_pin_oe_n;
    o_cfg <= cfg;
    o_device_enable <= !is_local || cfg.setup_sel;
    rom_addr_q <= rom_addr;
  end
endmodule // strap_rom_ctrl
`default_nettype wire

// >>> strap_rom_sva.sv
`default_nettype none
// Port checks for strap capture and ROM decode
module strap_rom_sva
  import strap_rom_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Requests
  input wire strap_rom_pkg::host_cycle_s i_cycle,
  input wire logic [7:0] i_reg_index,
  // Answers
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_bios_rom_select_n,
  input wire logic o_buffer_direction,
  input wire logic o_low_byte_buffer_enable_n,
  input wire logic o_high_byte_buffer_enable_n,
  input wire logic o_wide_memory_cycle_claim_n,
  input wire logic o_wide_memory_cycle_claim_oe_n,
  input wire logic o_no_wait_state_n,
  input wire logic o_upper_address_decode_two_oe_n,
  input wire logic o_cycle_ready_out,
  input wire strap_rom_pkg::strap_cfg_s o_cfg,
  input wire logic o_device_enable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ISA read below the hole, a hit whatever the range straps say
  sequence rom_rd;
    !$past(i_rst, 2) && o_cfg.bus == BUS_ISA && i_cycle.mem_read && i_cycle.addr >= BIOS_BASE
      && i_cycle.addr < BIOS_HOLE_BASE;
  endsequence
  // Reset lifted and configuration quiet, so registered modes have caught up
  sequence cfg_settled;
    !i_rst && $stable(o_cfg) ##1 $stable(o_cfg) ##1 $stable(o_cfg);
  endsequence
  reset_idle_a: assert property (disable iff (1'b0) i_rst |=> o_bios_rom_select_n && !o_cycle_ready_out)
    else $error("outputs not idle in reset");
  rom_select_a: assert property (rom_rd |=> !o_bios_rom_select_n)
    else $error("no ROM select on BIOS read");
  buffer_ctrl_a: assert property (rom_rd |=> !o_buffer_direction && !o_low_byte_buffer_enable_n
    && o_high_byte_buffer_enable_n == o_cfg.rom_8bit) else $error("buffer controls wrong");
  narrow_claim_a: assert property (rom_rd ##0 o_cfg.rom_8bit |=> o_wide_memory_cycle_claim_n
    || o_wide_memory_cycle_claim_oe_n) else $error("wide claim on narrow ROM");
  outside_miss_a: assert property (i_cycle.addr < BIOS_BASE || i_cycle.addr > BIOS_LAST |=> o_bios_rom_select_n)
    else $error("ROM select outside window");
  no_wait_a: assert property (rom_rd |=> o_no_wait_state_n == !o_cfg.no_wait_en)
    else $error("no-wait level wrong");
  upper_pin_a: assert property (cfg_settled |-> o_upper_address_decode_two_oe_n
    == !(o_cfg.bus == BUS_LOCAL && !o_cfg.upper_sel)) else $error("upper pin direction wrong");
  dev_enable_a: assert property (cfg_settled |-> o_device_enable
    == !(o_cfg.bus == BUS_LOCAL && !o_cfg.setup_sel)) else $error("device enable wrong");
  reserved_one_a: assert property (!$past(i_rst) && $past(i_reg_index) == IDX_STRAP_CAPTURE_HIGH |-> o_reg_rdata[1])
    else $error("reserved strap bit reads 0");
endmodule // strap_rom_sva
bind strap_rom_ctrl strap_rom_sva u_sva (.*);
`default_nettype wire

// >>> strap_board_model.sv
`default_nettype none
// Board side of the pixel bus: strap resistors, then live pixels
module strap_board_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Chosen strap levels
  input wire logic [15:0] i_strap,
  // Pixel bus seen by the device
  output logic [15:0] o_pd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic held = 1'b1;
  logic [15:0] pixel = 16'h0000;
  // Straps last one edge past reset fall only, so late sampling fails
  always @(posedge i_clk) begin
    held <= i_rst;
    pixel <= pixel + 16'h1;
  end
  assign o_pd = (held || i_rst) ? i_strap : pixel ^ ~i_strap;
endmodule // strap_board_model
`default_nettype wire

// >>> strap_rom_ctrl_test.sv
`default_nettype none
module strap_rom_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import strap_rom_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_reg_write = 1'b0, i_dac_access = 1'b0;
  logic i_upper_address_decode_two = 1'b1;
  logic [7:0] i_reg_index = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  logic [23:16] i_upper_addr = 8'h00;
  logic [15:0] strap = 16'h0000, i_strap_pixel_bus;
  host_cycle_s i_cycle = '0;
  strap_cfg_s o_cfg;
  logic o_upper_address_decode_two, o_upper_address_decode_two_oe_n, o_bios_rom_select_n, o_buffer_direction;
  logic o_low_byte_buffer_enable_n, o_high_byte_buffer_enable_n, o_wide_memory_cycle_claim_n;
  logic o_wide_memory_cycle_claim_oe_n, o_no_wait_state_n, o_local_bus_claim_n, o_local_bus_claim_oe_n;
  logic o_cycle_ready_out, o_device_enable;
  int num_errors = 0, total_checks = 0;
  logic [15:0] straps [7] = '{16'hb903, 16'h46ef, 16'h1a41, 16'h0381, 16'h00d0, 16'h56ff, 16'h1b01};
  logic [19:0] addrs [8] = '{20'hc0000, 20'hc5fff, 20'hc6000, 20'hc67ff, 20'hc6800, 20'hc7fff, 20'hc8000, 20'hbffff};
  // Clock keeps running through reset
  always #10 i_clk = ~i_clk;
  strap_board_model board (.i_clk, .i_rst, .i_strap(strap), .o_pd(i_strap_pixel_bus));
  strap_rom_ctrl DUT (.*);
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reset with new straps; the fall edge captures them
  task automatic boot(input logic [15:0] s);
    @(posedge i_clk);
    strap <= s;
    i_rst <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_index <= idx;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_clk);
    i_reg_write <= 1'b0;
  endtask
  // Read data lags the index by one edge
  task automatic reg_chk(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge i_clk);
    i_reg_index <= idx;
    @(posedge i_clk);
    #1 chk({8'h00, o_reg_rdata}, {8'h00, exp});
  endtask
  // One memory read, outputs judged one edge later
  task automatic cyc(input logic [19:0] a, input logic full);
    logic hit;
    logic wide_claim;
    hit = a >= BIOS_BASE && a <= BIOS_LAST && (full || a < BIOS_HOLE_BASE || a > BIOS_HOLE_LAST);
    wide_claim = strap[12] && a[19:17] == 3'b110 && (strap[4] || !a[16]) && !(hit && strap[2]);
    @(posedge i_clk);
    i_cycle <= '{a, 1'b1, 1'b0};
    i_upper_addr <= {4'h0, a[19:16]};
    @(posedge i_clk);
    #1;
    if (strap[1:0] != 2'b11) chk({15'h0, o_upper_address_decode_two}, {15'h0, !hit});
    else if (hit) chk({11'h0, o_bios_rom_select_n, o_low_byte_buffer_enable_n, o_high_byte_buffer_enable_n,
      o_buffer_direction, o_no_wait_state_n}, {13'h0, strap[2], 1'b0, !strap[11]});
    else chk({14'h0, o_bios_rom_select_n, o_low_byte_buffer_enable_n}, 16'h0003);
    if (strap[1:0] == 2'b11) chk({14'h0, o_wide_memory_cycle_claim_n, o_wide_memory_cycle_claim_oe_n},
      {14'h0, {2{!wide_claim}}});
  endtask
  initial begin
    logic dac_claim;
    foreach (straps[k]) begin
      boot(straps[k]);
      reg_chk(IDX_MEM_CONFIG, 8'h00);
      reg_chk(IDX_STRAP_CAPTURE_LOW, straps[k][7:0]);
      reg_chk(IDX_STRAP_CAPTURE_HIGH, {straps[k][15:10], 1'b1, straps[k][8]});
      reg_wr(IDX_STRAP_CAPTURE_LOW, ~straps[k][7:0]);
      reg_chk(IDX_STRAP_CAPTURE_LOW, straps[k][7:0]);
      chk({o_cfg.bus, o_cfg.mem_size, o_cfg.monitor_code},
        {straps[k][1:0], straps[k][7:5], straps[k][15:13], straps[k][10]});
      chk({15'h0, o_device_enable}, {15'h0, !(straps[k][1:0] == 2'b01 && !straps[k][8])});
      chk({15'h0, o_upper_address_decode_two_oe_n}, {15'h0, !(straps[k][1:0] == 2'b01 && !straps[k][4])});
      foreach (addrs[j]) begin
        if (straps[k][1:0] == 2'b11 || (straps[k][1:0] == 2'b01 && straps[k][8] && (j < 2 || j > 3))) begin
          cyc(addrs[j], straps[k][3]);
        end
      end
      if (k == 0) begin
        reg_wr(IDX_MEM_CONFIG, 8'h80);
        reg_chk(IDX_MEM_CONFIG, 8'h80);
        cyc(20'hc6000, 1'b1);
        reg_wr(IDX_MEM_CONFIG, 8'h00);
        cyc(20'hc6000, 1'b0);
        // Left set so the next reset must clear it
        reg_wr(IDX_MEM_CONFIG, 8'h80);
      end
      if (straps[k][1:0] == 2'b01) begin
        dac_claim = straps[k][12] && straps[k][8];
        @(posedge i_clk);
        i_cycle <= '0;
        i_dac_access <= 1'b1;
        @(posedge i_clk);
        #1 chk({13'h0, o_local_bus_claim_n, o_local_bus_claim_oe_n, o_cycle_ready_out},
          {13'h0, !dac_claim, straps[k][11] && !dac_claim, dac_claim});
        i_dac_access <= 1'b0;
      end
    end
    report_and_stop();
  end
  // Hang guard
  initial begin
    #200us;
    num_errors++;
    report_and_stop();
  end
endmodule // strap_rom_ctrl_test
`default_nettype wire
